// File: verilog/csf_flags.sv
// system flag relays of a programmable controller with an AXI4-Lite slave.
// assumes: one clock, scan and error event inputs come from logic on sys_clk.
//
// Operation
// [RULE1] run monitor: off at reset, on in run
// [RULE2] inverted run monitor: on at reset, off in run
// [RULE3] high pulse on run activation, else off
// [RULE4] low pulse on run activation, else on
// [RULE5] pulses last exactly the first scan
// [RULE6] syntax flag: set on error, cleared entering run
// [RULE7] watchdog flag: set on timeout, cleared entering run
// [RULE8] 10 ms clock flag, 5 ms halves
// [RULE9] 100 ms clock flag, 50 ms halves
// [RULE10] 1 s clock flag, 0.5 s halves
// [RULE11] 1 min clock flag, 30 s halves
// [RULE12] unchanged flags keep value across run changes
// [RULE13] read-only flags ignore program writes
// [RULE14] writable year display mode bit, reset clear
// [RULE15] writable thirty second clock correction bit
// [RULE16] writable angle unit bit, on means degrees
// [RULE17] writable fast timer enable, reset clear
`include "csf_defines.svh"

module csf_flags #(
    parameter int unsigned HalfTickCycles = `CSF_T10MS_HALF_US * `CSF_NS_PER_US / `CSF_CLK_PERIOD_NS
) (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire csf_pkg::csf_addr_t   awaddr,
    input  wire logic                 wvalid,
    output logic                      wready,
    input  wire csf_pkg::csf_data_t   wdata,
    input  wire logic [3:0]           wstrb,
    output logic                      bvalid,
    input  wire logic                 bready,
    output csf_pkg::csf_resp_t        bresp,
    input  wire logic                 arvalid,
    output logic                      arready,
    input  wire csf_pkg::csf_addr_t   araddr,
    output logic                      rvalid,
    input  wire logic                 rready,
    output csf_pkg::csf_data_t        rdata,
    output csf_pkg::csf_resp_t        rresp,
    input  wire logic                 scanDone,
    input  wire logic                 syntaxErrEvent,
    input  wire logic                 watchdogTimeoutEvent,
    output logic                      runMonitorFlag,
    output logic                      runMonitorInvertedFlag,
    output logic                      firstScanHighPulse,
    output logic                      firstScanLowPulse,
    output logic                      syntaxErrorFlag,
    output logic                      scanWatchdogTimeoutFlag,
    output logic                      tick10msFlag,
    output logic                      tick100msFlag,
    output logic                      tick1sFlag,
    output logic                      tick1minFlag,
    output logic                      fastTimerEnable,
    output logic                      clockYearFormatSelect,
    output logic                      clockThirtySecondAdjust,
    output logic                      angleUnitDegreeSelect,
    output logic                      irq
);
    import csf_pkg::*;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function automatic csf_sel_t csfDecode(input csf_addr_t a);
        csf_sel_t s;
        s = '0;
        case (a)
            `CSF_OFF_CTRL:       s[`CSF_SEL_CTRL]   = 1'b1;
            `CSF_OFF_FLAGS:      s[`CSF_SEL_FLAGS]  = 1'b1;
            `CSF_OFF_IRQ_STATUS: s[`CSF_SEL_STATUS] = 1'b1;
            `CSF_OFF_IRQ_MASK:   s[`CSF_SEL_MASK]   = 1'b1;
            default:             s = '0;
        endcase
        return s;
    endfunction : csfDecode

    // ------------------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------------------
    logic                      awHeld_ff;
    csf_addr_t                 awAddr_ff;
    logic                      wHeld_ff;
    csf_data_t                 wData_ff;
    logic                      wStrb0_ff;
    logic                      bvalid_ff;
    csf_resp_t                 bresp_ff;
    logic [`CSF_CTRL_W-1:0]    ctrl_ff;
    logic [`CSF_IRQ_W-1:0]     mask_ff;
    logic [`CSF_IRQ_W-1:0]     status_ff;

    wire       doWrite   = awHeld_ff & wHeld_ff & ~bvalid_ff;
    csf_sel_t  wrSel;
    assign wrSel = csfDecode(awAddr_ff);
    wire       wrLowByte = doWrite & wStrb0_ff;
    wire       wrCtrl    = wrLowByte & wrSel[`CSF_SEL_CTRL];
    wire       wrMask    = wrLowByte & wrSel[`CSF_SEL_MASK];
    wire       wrStatus  = wrLowByte & wrSel[`CSF_SEL_STATUS];

    // address and data are held apart, so either may arrive first
    assign awready = ~awHeld_ff;
    assign wready  = ~wHeld_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end else if (awvalid && !awHeld_ff) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wHeld_ff  <= 1'b0;
            wData_ff  <= '0;
            wStrb0_ff <= 1'b0;
        end else if (wvalid && !wHeld_ff) begin
            wHeld_ff  <= 1'b1;
            wData_ff  <= wdata;
            wStrb0_ff <= wstrb[0];
        end else if (doWrite) begin
            wHeld_ff  <= 1'b0;
        end
    end

    // writes to the flag word are accepted with OKAY and dropped
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `CSF_RESP_OKAY;
        end else if (doWrite) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (|wrSel) ? `CSF_RESP_OKAY : `CSF_RESP_SLVERR; // RULE13
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff <= `CSF_CTRL_RESET; // RULE14 RULE15 RULE16 RULE17
            mask_ff <= `CSF_IRQ_RESET;
        end else begin
            if (wrCtrl) ctrl_ff <= wData_ff[`CSF_CTRL_W-1:0];
            if (wrMask) mask_ff <= wData_ff[`CSF_IRQ_W-1:0];
        end
    end

    assign fastTimerEnable         = ctrl_ff[`CSF_CTRL_FAST_TMR]; // RULE17
    assign clockYearFormatSelect   = ctrl_ff[`CSF_CTRL_YEAR_FMT]; // RULE14
    assign clockThirtySecondAdjust = ctrl_ff[`CSF_CTRL_ADJ30];    // RULE15
    assign angleUnitDegreeSelect   = ctrl_ff[`CSF_CTRL_DEGREE];   // RULE16

    // ------------------------------------------------------------------------
    // run state
    // ------------------------------------------------------------------------
    csf_run_t  state_ff;
    csf_run_t  nxt_state;
    wire       runReq = ctrl_ff[`CSF_CTRL_RUN];
    // pulse ends on the scan end sample, not on a timer

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CSF_ST_STOP:  if (runReq) nxt_state = CSF_ST_FIRST;
            CSF_ST_FIRST: begin
                if (!runReq) nxt_state = CSF_ST_STOP;
                else if (scanDone) nxt_state = CSF_ST_RUN; // RULE5
            end
            CSF_ST_RUN:   if (!runReq) nxt_state = CSF_ST_STOP;
            default:      nxt_state = CSF_ST_STOP;
        endcase
    end

    wire runEntry = (state_ff == CSF_ST_STOP) & (nxt_state == CSF_ST_FIRST);
    wire runExit  = (state_ff != CSF_ST_STOP) & (nxt_state == CSF_ST_STOP);

    // flags follow the next state so they change on the transition edge itself
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff               <= CSF_ST_STOP;
            runMonitorFlag         <= 1'b0;
            runMonitorInvertedFlag <= 1'b1;
            firstScanHighPulse     <= 1'b0;
            firstScanLowPulse      <= 1'b1;
        end else begin
            state_ff               <= nxt_state;
            runMonitorFlag         <= (nxt_state != CSF_ST_STOP); // RULE1
            runMonitorInvertedFlag <= (nxt_state == CSF_ST_STOP); // RULE2
            firstScanHighPulse     <= (nxt_state == CSF_ST_FIRST); // RULE3 RULE5
            firstScanLowPulse      <= (nxt_state != CSF_ST_FIRST); // RULE4 RULE5
        end
    end

    // ------------------------------------------------------------------------
    // error flags: an event in the entry cycle survives the clear
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syntaxErrorFlag         <= 1'b0;
            scanWatchdogTimeoutFlag <= 1'b0;
        end else begin
            syntaxErrorFlag         <= syntaxErrEvent | (syntaxErrorFlag & ~runEntry); // RULE6 RULE12
            scanWatchdogTimeoutFlag <= watchdogTimeoutEvent
                                     | (scanWatchdogTimeoutFlag & ~runEntry); // RULE7 RULE12
        end
    end

    // ------------------------------------------------------------------------
    // free-running clock flags, independent of run state
    // ------------------------------------------------------------------------
    localparam logic [`CSF_DIV_W-1:0] TickRatio [`CSF_TICK_N] = '{
        `CSF_DIV_W'(1),
        `CSF_DIV_W'(`CSF_T100MS_HALF_US / `CSF_T10MS_HALF_US),
        `CSF_DIV_W'(`CSF_T1S_HALF_US / `CSF_T10MS_HALF_US),
        `CSF_DIV_W'(`CSF_T1MIN_HALF_US / `CSF_T10MS_HALF_US)
    };

    logic [`CSF_BASE_W-1:0]  baseCnt_ff;
    logic [`CSF_TICK_N-1:0]  tick_ff;
    logic [`CSF_TICK_N-1:0]  tickStrobe;
    wire  baseStrobe = (baseCnt_ff == `CSF_BASE_W'(HalfTickCycles - 1));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) baseCnt_ff <= '0;
        else if (baseStrobe) baseCnt_ff <= '0;
        else baseCnt_ff <= baseCnt_ff + `CSF_BASE_W'(1);
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CSF_TICK_N; gi++) begin : g_tick
            logic [`CSF_DIV_W-1:0] divCnt_ff;
            assign tickStrobe[gi] = baseStrobe & (divCnt_ff == TickRatio[gi] - `CSF_DIV_W'(1));
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    divCnt_ff   <= '0;
                    tick_ff[gi] <= 1'b0;
                end else if (tickStrobe[gi]) begin
                    divCnt_ff   <= '0;
                    tick_ff[gi] <= ~tick_ff[gi]; // RULE8 RULE9 RULE10 RULE11 RULE12
                end else if (baseStrobe) begin
                    divCnt_ff   <= divCnt_ff + `CSF_DIV_W'(1);
                end
            end
        end
    endgenerate

    assign tick10msFlag  = tick_ff[0]; // RULE8
    assign tick100msFlag = tick_ff[1]; // RULE9
    assign tick1sFlag    = tick_ff[2]; // RULE10
    assign tick1minFlag  = tick_ff[3]; // RULE11

    // ------------------------------------------------------------------------
    // interrupts: sticky, write one to clear, set wins over clear
    // ------------------------------------------------------------------------
    logic [`CSF_IRQ_W-1:0] irqEvent;
    logic [`CSF_IRQ_W-1:0] irqClear;
    logic [`CSF_IRQ_W-1:0] nxt_status;
    logic                  irq_ff;

    assign irqEvent[`CSF_IRQ_RUN_ENTRY] = runEntry;
    assign irqEvent[`CSF_IRQ_RUN_EXIT]  = runExit;
    assign irqEvent[`CSF_IRQ_SYNTAX]    = syntaxErrEvent;
    assign irqEvent[`CSF_IRQ_WDOG]      = watchdogTimeoutEvent;
    assign irqClear   = wrStatus ? wData_ff[`CSF_IRQ_W-1:0] : '0;
    assign nxt_status = (status_ff & ~irqClear) | irqEvent;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_ff <= `CSF_IRQ_RESET;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff    <= |(nxt_status & (wrMask ? wData_ff[`CSF_IRQ_W-1:0] : mask_ff));
        end
    end
    assign irq = irq_ff;

    // ------------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------------
    logic [`CSF_FLAG_W-1:0] flagWord;
    csf_sel_t               rdSel;
    csf_data_t              rdMux;
    logic                   rvalid_ff;
    csf_data_t              rdata_ff;
    csf_resp_t              rresp_ff;

    assign flagWord = {tick_ff, scanWatchdogTimeoutFlag, syntaxErrorFlag, firstScanLowPulse,
                       firstScanHighPulse, runMonitorInvertedFlag, runMonitorFlag};
    assign rdSel    = csfDecode(araddr);
    assign rdMux    = ({`CSF_DW{rdSel[`CSF_SEL_CTRL]}}   & `CSF_DW'(ctrl_ff))
                    | ({`CSF_DW{rdSel[`CSF_SEL_FLAGS]}}  & `CSF_DW'(flagWord))
                    | ({`CSF_DW{rdSel[`CSF_SEL_STATUS]}} & `CSF_DW'(status_ff))
                    | ({`CSF_DW{rdSel[`CSF_SEL_MASK]}}   & `CSF_DW'(mask_ff));
    assign arready  = ~rvalid_ff;
    assign rvalid   = rvalid_ff;
    assign rdata    = rdata_ff;
    assign rresp    = rresp_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= `CSF_RESP_OKAY;
        end else if (arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rdMux;
            rresp_ff  <= (|rdSel) ? `CSF_RESP_OKAY : `CSF_RESP_SLVERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    chk_run_entry_flags: assert property (runEntry |=> runMonitorFlag && firstScanHighPulse) // RULE1
        else $error("run entry did not raise monitor and pulse");
    chk_run_inverted: assert property (runMonitorInvertedFlag == !runMonitorFlag) // RULE2
        else $error("inverted run monitor disagrees");
    chk_pulse_pair: assert property (firstScanLowPulse == !firstScanHighPulse) // RULE4
        else $error("low pulse not complement of high pulse");
    chk_pulse_one_scan: assert property (
        firstScanHighPulse && scanDone && runReq |=> !firstScanHighPulse [*2]) // RULE5
        else $error("first scan pulse outlived first scan");
    chk_stop_drops: assert property (runExit |=> !runMonitorFlag && !firstScanHighPulse) // RULE3
        else $error("stop did not drop run flags");
    chk_syntax_clear: assert property (runEntry && !syntaxErrEvent |=> !syntaxErrorFlag) // RULE6
        else $error("syntax flag not cleared on run entry");
    chk_syntax_keep: assert property (
        runExit && !syntaxErrEvent |=> syntaxErrorFlag == $past(syntaxErrorFlag)) // RULE6
        else $error("syntax flag changed on stop");
    chk_wdog_set: assert property (watchdogTimeoutEvent |=> scanWatchdogTimeoutFlag) // RULE7
        else $error("watchdog flag not set");
    chk_tick_toggle: assert property (
        1'b1 |=> tick10msFlag == ($past(tick10msFlag) ^ $past(baseStrobe))) // RULE8
        else $error("10 ms flag toggled off its strobe");
    chk_tick_slow: assert property (
        !tickStrobe[3] |=> tick1minFlag == $past(tick1minFlag)) // RULE11
        else $error("1 min flag moved between strobes");
    chk_ctrl_across_run: assert property (
        runEntry || runExit |=> $stable(ctrl_ff[`CSF_CTRL_W-1:`CSF_CTRL_FAST_TMR])) // RULE12
        else $error("writable bits moved on run change");
    chk_flags_readonly: assert property (
        doWrite && wrSel[`CSF_SEL_FLAGS] && !runEntry && !runExit
        |=> $stable(runMonitorFlag) && $stable(ctrl_ff) && $stable(mask_ff)) // RULE13
        else $error("flag word write changed a flag");
    chk_irq_level: assert property (irq == |(status_ff & mask_ff))
        else $error("irq out of step with status and mask");
    chk_status_set_wins: assert property (
        irqEvent != '0 |=> (status_ff & $past(irqEvent)) == $past(irqEvent))
        else $error("status event lost");

endmodule : csf_flags

// File: pkg/csf_defines.svh
// constants for the controller system flag block: register map, field
// positions, reset values and timing figures.
// assumes: included by its bare name from the package and the design file.
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH

// ----------------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------------
`define CSF_AW              8
`define CSF_DW              32
`define CSF_RESP_OKAY       2'h0
`define CSF_RESP_SLVERR     2'h2

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CSF_OFF_CTRL        8'h00
`define CSF_OFF_FLAGS       8'h04
`define CSF_OFF_IRQ_STATUS  8'h08
`define CSF_OFF_IRQ_MASK    8'h0c

// decoded register select positions
`define CSF_SEL_W           4
`define CSF_SEL_CTRL        0
`define CSF_SEL_FLAGS       1
`define CSF_SEL_STATUS      2
`define CSF_SEL_MASK        3

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CSF_CTRL_W          5
`define CSF_CTRL_RUN        0
`define CSF_CTRL_FAST_TMR   1
`define CSF_CTRL_YEAR_FMT   2
`define CSF_CTRL_ADJ30      3
`define CSF_CTRL_DEGREE     4
`define CSF_CTRL_RESET      5'h00

// ----------------------------------------------------------------------------
// flag register fields (read only)
// ----------------------------------------------------------------------------
`define CSF_FLAG_W          10
`define CSF_FLAG_RUN_MON    0
`define CSF_FLAG_RUN_INV    1
`define CSF_FLAG_HI_PULSE   2
`define CSF_FLAG_LO_PULSE   3
`define CSF_FLAG_SYNTAX     4
`define CSF_FLAG_WDOG       5
`define CSF_FLAG_TICK0      6

// ----------------------------------------------------------------------------
// interrupt status / mask fields
// ----------------------------------------------------------------------------
`define CSF_IRQ_W           4
`define CSF_IRQ_RUN_ENTRY   0
`define CSF_IRQ_RUN_EXIT    1
`define CSF_IRQ_SYNTAX      2
`define CSF_IRQ_WDOG        3
`define CSF_IRQ_RESET       4'h0

// ----------------------------------------------------------------------------
// timing: half periods of the free-running clock flags, in microseconds
// ----------------------------------------------------------------------------
`define CSF_CLK_PERIOD_NS   5
`define CSF_T10MS_HALF_US   5000
`define CSF_T100MS_HALF_US  50000
`define CSF_T1S_HALF_US     500000
`define CSF_T1MIN_HALF_US   30000000
`define CSF_NS_PER_US       1000
`define CSF_BASE_W          20
`define CSF_DIV_W           13
`define CSF_TICK_N          4

`endif

// File: pkg/csf_pkg.sv
// types shared by the controller system flag block.
// assumes: csf_defines.svh is on the include path.
`include "csf_defines.svh"

package csf_pkg;

    // gray path: stop -> first scan -> run
    typedef enum logic [1:0] {
        CSF_ST_STOP  = 2'b00,
        CSF_ST_FIRST = 2'b01,
        CSF_ST_RUN   = 2'b11
    } csf_run_t;

    typedef logic [1:0]              csf_resp_t;
    typedef logic [`CSF_AW-1:0]      csf_addr_t;
    typedef logic [`CSF_DW-1:0]      csf_data_t;
    typedef logic [`CSF_SEL_W-1:0]   csf_sel_t;

endpackage : csf_pkg

// File: verif/csf_flags_tb_top.sv
// self-checking bench for the system flag block; a bench model is compared at every result.
// assumes: csf_pkg compiled first, csf_defines.svh on the include path, tick half shortened to 4 cycles.
`include "csf_defines.svh"

module csf_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csf_pkg::*;

    localparam int H = 4;
    logic sys_clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, scanDone = 1'b0, syntaxErrEvent = 1'b0, watchdogTimeoutEvent = 1'b0;
    csf_addr_t awaddr = 8'h00, araddr = 8'h00;
    csf_data_t wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, runMonitorFlag, runMonitorInvertedFlag;
    logic firstScanHighPulse, firstScanLowPulse, syntaxErrorFlag, scanWatchdogTimeoutFlag, tick10msFlag;
    logic tick100msFlag, tick1sFlag, tick1minFlag, fastTimerEnable, clockYearFormatSelect;
    logic clockThirtySecondAdjust, angleUnitDegreeSelect;
    csf_resp_t bresp, rresp;
    int num_errors = 0, check_count = 0, ctrlM = 0, statM = 0, maskM = 0, runM = 0, pulM = 0, synM = 0, wdgM = 0;
    int unsigned seed = 1;
    wire [3:0] tk = {tick1minFlag, tick1sFlag, tick100msFlag, tick10msFlag};

    csf_flags #(.HalfTickCycles(H)) dut_u (
        .sys_clk, .arst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .scanDone, .syntaxErrEvent,
        .watchdogTimeoutEvent, .runMonitorFlag, .runMonitorInvertedFlag, .firstScanHighPulse,
        .firstScanLowPulse, .syntaxErrorFlag, .scanWatchdogTimeoutFlag, .tick10msFlag, .tick100msFlag,
        .tick1sFlag, .tick1minFlag, .fastTimerEnable, .clockYearFormatSelect, .clockThirtySecondAdjust,
        .angleUnitDegreeSelect, .irq);

    always #2.5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // model and bus tasks
    // ------------------------------------------------------------
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic csf_data_t fexp();
        return {26'h0, wdgM[0], synM[0], ~pulM[0], pulM[0], ~runM[0], runM[0]};
    endfunction : fexp

    task automatic chk(input string nm, input csf_data_t exp, input csf_data_t got);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // outputs settle by the falling edge, so sample there
    task automatic cmp_all();
        @(negedge sys_clk);
        chk("outputs", fexp() | {ctrlM[4:1], 6'h0} | {(statM & maskM) != 0, 10'h0},
            {21'h0, irq, angleUnitDegreeSelect, clockThirtySecondAdjust, clockYearFormatSelect, fastTimerEnable,
             scanWatchdogTimeoutFlag, syntaxErrorFlag, firstScanLowPulse, firstScanHighPulse,
             runMonitorInvertedFlag, runMonitorFlag});
    endtask : cmp_all

    task automatic mdl_wr(input csf_addr_t a, input csf_data_t v);
        if (a == `CSF_OFF_CTRL) begin
            if (v[0] && !runM) begin
                {runM, pulM, synM, wdgM} = {32'd1, 32'd1, 32'd0, 32'd0};
                statM |= 1;
            end
            if (!v[0] && runM) begin
                {runM, pulM} = {32'd0, 32'd0};
                statM |= 2;
            end
            ctrlM = v & 32'h1f;
        end
        if (a == `CSF_OFF_IRQ_STATUS) statM &= ~v;
        if (a == `CSF_OFF_IRQ_MASK) maskM = v & 32'hf;
    endtask : mdl_wr

    // handshake values are taken at the falling edge before the rising edge that uses them
    task automatic wr(input csf_addr_t a, input csf_data_t v, input logic [3:0] s, input csf_resp_t er);
        logic aw, w, b;
        csf_resp_t r;
        b = 1'b0;
        @(posedge sys_clk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        while (!b) begin
            @(negedge sys_clk);
            {aw, w, b, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge sys_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
        chk("bresp", er, r);
        if (b && r === 2'h0 && s[0]) mdl_wr(a, v);
    endtask : wr

    task automatic rd(input csf_addr_t a, input csf_data_t m, input csf_data_t ed, input csf_resp_t er);
        logic ar, b;
        csf_resp_t r;
        csf_data_t dt;
        b = 1'b0;
        @(posedge sys_clk);
        {arvalid, rready} <= 2'h3;
        araddr <= a;
        while (!b) begin
            @(negedge sys_clk);
            {ar, b, r, dt} = {arvalid & arready, rvalid, rresp, rdata};
            @(posedge sys_clk);
            if (ar) arvalid <= 1'b0;
            if (b) rready <= 1'b0;
        end
        chk("rresp", er, r);
        chk("rdata", ed & m, dt & m);
    endtask : rd

    // k: 0 end of scan, 1 syntax error, 2 watchdog timeout
    task automatic ev(input int k);
        @(posedge sys_clk);
        {scanDone, syntaxErrEvent, watchdogTimeoutEvent} <= {k == 0, k == 1, k == 2};
        @(posedge sys_clk);
        {scanDone, syntaxErrEvent, watchdogTimeoutEvent} <= 3'h0;
        if (k == 0 && runM) pulM = 0;
        if (k == 1) {synM, statM} = {32'd1, statM | 4};
        if (k == 2) {wdgM, statM} = {32'd1, statM | 8};
        @(posedge sys_clk);
        cmp_all();
    endtask : ev

    // half periods measured between toggles; the first toggle only starts the count
    logic [3:0] tkPrev = 4'h0;
    int tkLen[4] = '{default: 0};
    int tkSeen[4] = '{default: 0};
    int tkHalf[4] = '{H, 10 * H, 100 * H, 6000 * H};
    always @(negedge sys_clk) begin
        if (arst_n) begin
            for (int i = 0; i < 4; i++) begin
                tkLen[i]++;
                if (tk[i] !== tkPrev[i]) begin
                    if (tkSeen[i] > 0) chk("tick half period", tkHalf[i], tkLen[i]);
                    tkSeen[i]++;
                    tkLen[i] = 0;
                end
            end
        end
        tkPrev = tk;
    end

    initial begin
        #400000;
        num_errors++;
        $display("watchdog expired before the tests ended");
        end_of_test();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        cmp_all();
        chk("ticks after reset", 32'h0, {28'h0, tk});
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            d = xs() & 32'h1e;
            wr(`CSF_OFF_CTRL, d, 4'hf, `CSF_RESP_OKAY);
            cmp_all();
            rd(`CSF_OFF_CTRL, 32'hffffffff, ctrlM, `CSF_RESP_OKAY);
        end
        wr(`CSF_OFF_CTRL, ctrlM ^ 32'h1e, 4'he, `CSF_RESP_OKAY);
        cmp_all();
        wr(`CSF_OFF_FLAGS, 32'h3ff, 4'hf, `CSF_RESP_OKAY);
        cmp_all();
        rd(`CSF_OFF_FLAGS, 32'hfffffc3f, fexp(), `CSF_RESP_OKAY);
        wr(8'h10, 32'h1f, 4'hf, `CSF_RESP_SLVERR);
        rd(8'h10, 32'hffffffff, 32'h0, `CSF_RESP_SLVERR);
        $display("test registers done");
        ev(1);
        ev(2);
        ev(0);
        wr(`CSF_OFF_CTRL, ctrlM | 1, 4'hf, `CSF_RESP_OKAY);
        cmp_all();
        repeat (3) @(posedge sys_clk);
        cmp_all();
        ev(0);
        ev(0);
        ev(1);
        ev(2);
        rd(`CSF_OFF_FLAGS, 32'hfffffc3f, fexp(), `CSF_RESP_OKAY);
        wr(`CSF_OFF_CTRL, ctrlM & 32'h1e, 4'hf, `CSF_RESP_OKAY);
        cmp_all();
        $display("test run and stop done");
        wr(`CSF_OFF_IRQ_MASK, xs() & 32'hf, 4'hf, `CSF_RESP_OKAY);
        cmp_all();
        wr(`CSF_OFF_IRQ_MASK, 32'hf, 4'hf, `CSF_RESP_OKAY);
        rd(`CSF_OFF_IRQ_MASK, 32'hffffffff, maskM, `CSF_RESP_OKAY);
        cmp_all();
        rd(`CSF_OFF_IRQ_STATUS, 32'hffffffff, statM, `CSF_RESP_OKAY);
        wr(`CSF_OFF_IRQ_STATUS, 32'h5, 4'hf, `CSF_RESP_OKAY);
        cmp_all();
        wr(`CSF_OFF_IRQ_STATUS, 32'hffffffff, 4'hf, `CSF_RESP_OKAY);
        cmp_all();
        rd(`CSF_OFF_IRQ_STATUS, 32'hffffffff, statM, `CSF_RESP_OKAY);
        $display("test interrupts done");
        for (int n = 0; n < 60000 && tkSeen[3] < 2; n++) @(posedge sys_clk);
        chk("minute tick toggles", 32'h2, tkSeen[3]);
        $display("test ticks done");
        end_of_test();
    end
endmodule : csf_flags_tb_top
